// ===== core/bfr_map.svh
// bfr_map.svh: register offsets, fields, reset values and counts for the bitmap fragment rasterizer.
// Assumes a 32-bit plain register port with word-aligned byte offsets.
`ifndef BFR_MAP_SVH
`define BFR_MAP_SVH
`define BFR_REG_CTRL 8'h00
`define BFR_REG_RPOS_X 8'h04
`define BFR_REG_RPOS_Y 8'h08
`define BFR_REG_RPOS_Z 8'h0C
`define BFR_REG_RPOS_W 8'h10
`define BFR_REG_COLOR 8'h14
`define BFR_REG_FOG 8'h18
`define BFR_REG_TEXC 8'h1C
`define BFR_REG_STATUS 8'h20
`define BFR_REG_ZOOM 8'h24
`define BFR_CTRL_MS_EN 0
`define BFR_CTRL_RP_VALID 1
`define BFR_CTRL_SSC_LO 8
`define BFR_CTRL_SSC_HI 11
`define BFR_STAT_BUSY 0
`define BFR_STAT_FB_ERR 1
`define BFR_STAT_IGNORED 2
`define BFR_CTRL_RESET 32'h0000_0000
`define BFR_SSC_ONE 4'h1
`define BFR_ZOOM_RESET 32'h0001_0001
`endif

// ===== core/bfr_pkg.sv
// bfr_pkg.sv: types shared by the bitmap fragment rasterizer.
// Assumes 16-bit integer window coordinates.
package bfr_pkg;
   typedef enum logic [1:0] {
      BFR_IDLE = 2'b00,
      BFR_LOAD = 2'b01,
      BFR_EMIT = 2'b10,
      BFR_DONE = 2'b11
   } bfr_state_e;
   typedef enum logic [1:0] {
      BFR_CMD_BITMAP = 2'b00,
      BFR_CMD_PIXRECT = 2'b01,
      BFR_CMD_NONE = 2'b10,
      BFR_CMD_RSVD = 2'b11
   } bfr_cmd_e;
   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [31:0] z;
      logic [31:0] color;
      logic [15:0] fog;
      logic [31:0] texc;
      logic [3:0] cov;
   } bfr_frag_s;
   typedef struct packed {
      bfr_cmd_e kind;
      logic [7:0] w;
      logic [7:0] h;
      logic [15:0] xo;
      logic [15:0] yo;
      logic [15:0] xi;
      logic [15:0] yi;
   } bfr_cmd_s;
endpackage

// ===== core/bfr_rasterizer.sv
// bfr_rasterizer.sv: turns bitmaps and pixel rectangles into fragments at the raster position.
// Assumes a host command port, a one-bit-per-handshake stipple stream and a downstream ready.
//
// Overview of operation
// - sample coverage on and store count one: pixel rectangles use multisample path.
// - pixel rectangle draw with invalid raster position emits no fragments.
// - multisample group n,m owns raster position plus zoom times (n,m) to (n+1,m+1).
// - one fragment per pixel with a sample inside or on bottom/left edge.
// - all depth and color samples share one value from group or raster position.
// - all samples share fog and texture coordinates from the raster position.
// - bitmap bits unpacked raw as one-bit values forming the stipple pattern.
// - invalid raster position: bitmap ignored, no fragments, position unchanged.
// - single-sample array lower left is floor(raster position minus origin).
// - single-sample: fragment only where bitmap bit is one.
// - every bitmap fragment carries the raster position's associated data.
// - after a bitmap, increments are added to raster x and y.
// - bitmap position update leaves z and w unchanged.
// - bitmap with valid raster position and incomplete draw target raises the incomplete-target error.
// - sample coverage on and store count one: bitmaps use multisample path.
// - multisample: cell grid from raster position, zero-bit cells discarded.
// - multisample: fragment per pixel with a sample in a retained cell.
// - coverage bit one for samples in retained cells, zero otherwise.
// - multisample bitmap updates raster position as in single-sample case.
`include "bfr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module bfr_rasterizer #(
   parameter int SAMPLES = 4
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire bfr_pkg::bfr_cmd_s cmd_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic bit_i,
   input wire logic bit_valid_i,
   output logic bit_ready_o,
   input wire logic draw_target_complete_i,
   output bfr_pkg::bfr_frag_s frag_o,
   output logic frag_valid_o,
   input wire logic frag_ready_i
);
   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_q;
   logic [15:0] rp_x_q, rp_y_q;
   logic [31:0] rp_z_q, rp_w_q, color_q, texc_q, zoom_q;
   logic [15:0] fog_q;
   logic fb_err_q, ignored_q;
   bfr_pkg::bfr_state_e state_q;
   bfr_pkg::bfr_cmd_s cmd_q;
   logic [7:0] col_q, row_q;
   logic [15:0] sub_x_q, sub_y_q;
   logic ms_q;
   logic bit_q;
   logic [31:0] rdata_q;
   bfr_pkg::bfr_frag_s frag_q;
   logic fvalid_q;

   // one address compare shared by the raster position write and status clear decode
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
      return (a == off);
   endfunction

   // multisample selected only for the single-store case
   wire ms_sel = ctrl_q[`BFR_CTRL_MS_EN] &&
      (ctrl_q[`BFR_CTRL_SSC_HI:`BFR_CTRL_SSC_LO] == `BFR_SSC_ONE);
   wire rp_valid = ctrl_q[`BFR_CTRL_RP_VALID];
   wire wr_rp_x = reg_wr_i && addr_hit(reg_addr_i, `BFR_REG_RPOS_X);
   wire wr_rp_y = reg_wr_i && addr_hit(reg_addr_i, `BFR_REG_RPOS_Y);
   wire busy = (state_q != bfr_pkg::BFR_IDLE);
   wire take_cmd = cmd_valid_i && !busy;
   wire is_bitmap = (cmd_i.kind == bfr_pkg::BFR_CMD_BITMAP);
   wire is_pixrect = (cmd_i.kind == bfr_pkg::BFR_CMD_PIXRECT);
   // invalid position, or an incomplete target for a bitmap, drops the whole command
   wire drop_cmd = !rp_valid || (is_bitmap && !draw_target_complete_i);
   wire out_free = !fvalid_q || frag_ready_i;
   wire bit_take = (state_q == bfr_pkg::BFR_LOAD) && bit_valid_i;
   wire last_col = (col_q == cmd_q.w - 8'h01);
   wire last_row = (row_q == cmd_q.h - 8'h01);
   wire zero_size = (cmd_i.w == 8'h00) || (cmd_i.h == 8'h00);

   // single-sample anchor: integer origin makes floor exact
   wire [15:0] ss_x = rp_x_q - cmd_q.xo;
   wire [15:0] ss_y = rp_y_q - cmd_q.yo;
   wire signed [15:0] zx = $signed(zoom_q[15:0]);
   wire signed [15:0] zy = $signed(zoom_q[31:16]);
   // each group covers |zoom| pixels per axis; a negative zoom puts them below or left of the corner
   wire [15:0] zx_mag = zx[15] ? 16'(-zx) : 16'(zx);
   wire [15:0] zy_mag = zy[15] ? 16'(-zy) : 16'(zy);
   wire zoom_zero = (zx_mag == 16'h0000) || (zy_mag == 16'h0000);
   wire [15:0] pr_lo_x = 16'(rp_x_q + 16'($signed({8'h00, col_q}) * zx) +
      (zx[15] ? zoom_q[15:0] : 16'h0000));
   wire [15:0] pr_lo_y = 16'(rp_y_q + 16'($signed({8'h00, row_q}) * zy) +
      (zy[15] ? zoom_q[31:16] : 16'h0000));
   wire [15:0] pr_x = pr_lo_x + sub_x_q;
   wire [15:0] pr_y = pr_lo_y + sub_y_q;
   wire [15:0] bm_x = (ms_q ? rp_x_q : ss_x) + {8'h00, col_q};
   wire [15:0] bm_y = (ms_q ? rp_y_q : ss_y) + {8'h00, row_q};
   wire is_pr = (cmd_q.kind == bfr_pkg::BFR_CMD_PIXRECT);

   ////////////////////////////////////////////////////////////////////////////
   // sub-pixel walk
   // bitmaps have one pixel per cell, so the walk is skipped for them
   wire last_sub_x = !is_pr || zoom_zero || (sub_x_q == zx_mag - 16'h0001);
   wire last_sub_y = !is_pr || zoom_zero || (sub_y_q == zy_mag - 16'h0001);
   wire last_sub = last_sub_x && last_sub_y;
   // a zero zoom leaves an empty footprint, but every group still consumes its bit
   wire emit_on = bit_q && !(is_pr && zoom_zero);
   wire step = out_free || !emit_on;

   // a retained cell covers all samples of its pixel since the grid is pixel aligned
   wire [3:0] cov_all = 4'((1 << SAMPLES) - 1);

   ////////////////////////////////////////////////////////////////////////////
   // control
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= bfr_pkg::BFR_IDLE;
         cmd_q <= '0;
         col_q <= 8'h00;
         row_q <= 8'h00;
         sub_x_q <= 16'h0000;
         sub_y_q <= 16'h0000;
         ms_q <= 1'b0;
         bit_q <= 1'b0;
         ignored_q <= 1'b0;
      end else begin
         case (state_q)
            bfr_pkg::BFR_IDLE: begin
               col_q <= 8'h00;
               row_q <= 8'h00;
               if (take_cmd && (is_bitmap || is_pixrect)) begin
                  cmd_q <= cmd_i;
                  ms_q <= ms_sel;
                  ignored_q <= drop_cmd;
                  if (!drop_cmd && !zero_size) begin
                     state_q <= bfr_pkg::BFR_LOAD;
                  end else if (!drop_cmd) begin
                     state_q <= bfr_pkg::BFR_DONE;
                  end
               end
            end
            bfr_pkg::BFR_LOAD: begin
               if (bit_take) begin
                  bit_q <= is_pr ? 1'b1 : bit_i;
                  state_q <= bfr_pkg::BFR_EMIT;
               end
            end
            bfr_pkg::BFR_EMIT: begin
               if (step && !last_sub) begin
                  // more pixels of this group's footprint, same stipple bit
                  sub_x_q <= last_sub_x ? 16'h0000 : sub_x_q + 16'h0001;
                  sub_y_q <= last_sub_x ? sub_y_q + 16'h0001 : sub_y_q;
               end else if (step) begin
                  sub_x_q <= 16'h0000;
                  sub_y_q <= 16'h0000;
                  if (last_col) begin
                     col_q <= 8'h00;
                     row_q <= row_q + 8'h01;
                  end else begin
                     col_q <= col_q + 8'h01;
                  end
                  state_q <= (last_col && last_row) ? bfr_pkg::BFR_DONE : bfr_pkg::BFR_LOAD;
               end
            end
            bfr_pkg::BFR_DONE: begin
               state_q <= bfr_pkg::BFR_IDLE;
            end
            default: state_q <= bfr_pkg::BFR_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fragment output
   // a fragment holds until the sink takes it, so a slow sink only stalls the walk
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         frag_q <= '0;
         fvalid_q <= 1'b0;
      end else if ((state_q == bfr_pkg::BFR_EMIT) && out_free && emit_on) begin
         fvalid_q <= 1'b1;
         frag_q.x <= is_pr ? pr_x : bm_x;
         frag_q.y <= is_pr ? pr_y : bm_y;
         frag_q.z <= rp_z_q;
         frag_q.color <= color_q;
         frag_q.fog <= fog_q;
         frag_q.texc <= texc_q;
         frag_q.cov <= (ms_q || is_pr) ? cov_all : 4'h0;
      end else if (frag_ready_i) begin
         fvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file and raster position update
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= `BFR_CTRL_RESET;
         rp_x_q <= 16'h0000;
         rp_y_q <= 16'h0000;
         rp_z_q <= 32'h0000_0000;
         rp_w_q <= 32'h0000_0000;
         color_q <= 32'h0000_0000;
         fog_q <= 16'h0000;
         texc_q <= 32'h0000_0000;
         zoom_q <= `BFR_ZOOM_RESET;
      end else begin
         if ((state_q == bfr_pkg::BFR_DONE) && (cmd_q.kind == bfr_pkg::BFR_CMD_BITMAP)) begin
            // same update in both modes; z and w untouched
            rp_x_q <= rp_x_q + cmd_q.xi;
            rp_y_q <= rp_y_q + cmd_q.yi;
         end else begin
            if (wr_rp_x) rp_x_q <= reg_wdata_i[15:0];
            if (wr_rp_y) rp_y_q <= reg_wdata_i[15:0];
         end
         if (reg_wr_i) begin
            case (reg_addr_i)
               `BFR_REG_CTRL: ctrl_q <= reg_wdata_i;
               `BFR_REG_RPOS_Z: rp_z_q <= reg_wdata_i;
               `BFR_REG_RPOS_W: rp_w_q <= reg_wdata_i;
               `BFR_REG_COLOR: color_q <= reg_wdata_i;
               `BFR_REG_FOG: fog_q <= reg_wdata_i[15:0];
               `BFR_REG_TEXC: texc_q <= reg_wdata_i;
               `BFR_REG_ZOOM: zoom_q <= reg_wdata_i;
               default: ;
            endcase
         end
      end
   end

   // sticky error: set wins over a clear written in the same cycle
   wire stat_clr = reg_wr_i && addr_hit(reg_addr_i, `BFR_REG_STATUS) && reg_wdata_i[`BFR_STAT_FB_ERR];
   wire fb_err_set = take_cmd && is_bitmap && rp_valid && !draw_target_complete_i;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fb_err_q <= 1'b0;
      end else if (fb_err_set) begin
         fb_err_q <= 1'b1;
      end else if (stat_clr) begin
         fb_err_q <= 1'b0;
      end
   end

   wire [31:0] rd_mux =
      (reg_addr_i == `BFR_REG_CTRL) ? ctrl_q :
      (reg_addr_i == `BFR_REG_RPOS_X) ? {16'h0000, rp_x_q} :
      (reg_addr_i == `BFR_REG_RPOS_Y) ? {16'h0000, rp_y_q} :
      (reg_addr_i == `BFR_REG_RPOS_Z) ? rp_z_q :
      (reg_addr_i == `BFR_REG_RPOS_W) ? rp_w_q :
      (reg_addr_i == `BFR_REG_COLOR) ? color_q :
      (reg_addr_i == `BFR_REG_FOG) ? {16'h0000, fog_q} :
      (reg_addr_i == `BFR_REG_TEXC) ? texc_q :
      (reg_addr_i == `BFR_REG_STATUS) ? {29'h0, ignored_q, fb_err_q, busy} :
      (reg_addr_i == `BFR_REG_ZOOM) ? zoom_q : 32'h0000_0000;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= reg_rd_i ? rd_mux : 32'h0000_0000;
      end
   end

   logic cmd_rdy_q, bit_rdy_q;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_rdy_q <= 1'b0;
         bit_rdy_q <= 1'b0;
      end else begin
         // registered ready lags one cycle; commands sampled only when idle
         cmd_rdy_q <= !busy && !take_cmd;
         bit_rdy_q <= (state_q == bfr_pkg::BFR_IDLE && take_cmd && !drop_cmd && !zero_size) ||
            (state_q == bfr_pkg::BFR_EMIT && step && last_sub && !(last_col && last_row));
      end
   end
   assign cmd_ready_o = cmd_rdy_q;
   assign bit_ready_o = bit_rdy_q;
   assign reg_rdata_o = rdata_q;
   assign frag_o = frag_q;
   assign frag_valid_o = fvalid_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_INVALID_NO_FRAG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == bfr_pkg::BFR_IDLE && take_cmd && !rp_valid) |=> (state_q == bfr_pkg::BFR_IDLE))
      else $error("command taken with invalid position");
   AST_BM_IGNORE_KEEPS_POS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (take_cmd && is_bitmap && !rp_valid && !wr_rp_x) |=> $stable(rp_x_q))
      else $error("ignored bitmap moved raster x");
   AST_POS_ADVANCE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == bfr_pkg::BFR_DONE && cmd_q.kind == bfr_pkg::BFR_CMD_BITMAP)
      |=> rp_x_q == $past(rp_x_q) + $past(cmd_q.xi))
      else $error("raster x not advanced by increment");
   AST_ZW_STABLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == bfr_pkg::BFR_DONE && !reg_wr_i) |=> $stable(rp_z_q) && $stable(rp_w_q))
      else $error("z or w changed by bitmap");
   AST_ZERO_BIT_NO_FRAG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == bfr_pkg::BFR_EMIT && !bit_q && !fvalid_q) |=> !fvalid_q)
      else $error("fragment from zero bit");
   AST_FRAG_DATA: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(fvalid_q) |-> frag_q.color == $past(color_q) && frag_q.z == $past(rp_z_q))
      else $error("fragment data not from raster position");
   AST_FOG_TEX: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(fvalid_q) |-> frag_q.fog == $past(fog_q) && frag_q.texc == $past(texc_q))
      else $error("fog or texcoord mismatch");
   AST_FB_ERR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      fb_err_set |=> fb_err_q)
      else $error("incomplete target error not raised");
   AST_MS_COV: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == bfr_pkg::BFR_EMIT && out_free && emit_on && !is_pr && ms_q) |=> frag_q.cov == cov_all)
      else $error("multisample coverage wrong");
   AST_SUB_RANGE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == bfr_pkg::BFR_EMIT && is_pr && !zoom_zero) |-> (sub_x_q < zx_mag) && (sub_y_q < zy_mag))
      else $error("pixel beyond group footprint");
   AST_FRAG_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (fvalid_q && !frag_ready_i) |=> fvalid_q && $stable(frag_q))
      else $error("fragment dropped before acceptance");
   AST_ONE_BIT_EMITS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == bfr_pkg::BFR_EMIT && bit_q && !is_pr && out_free) |=> fvalid_q)
      else $error("set stipple bit gave no fragment");
   // anchors are recomputed from the raster state, not taken from the position mux
   AST_SS_ANCHOR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == bfr_pkg::BFR_EMIT && !ms_q && !is_pr && out_free && emit_on)
      |=> frag_q.x == 16'($past(rp_x_q) - $past(cmd_q.xo) + {8'h00, $past(col_q)}))
      else $error("single-sample bitmap anchor wrong");
   AST_MS_ANCHOR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (state_q == bfr_pkg::BFR_EMIT && ms_q && !is_pr && out_free && emit_on)
      |=> frag_q.y == 16'($past(rp_y_q) + {8'h00, $past(row_q)}))
      else $error("multisample bitmap cell off the raster grid");
   COV_BITMAP: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      state_q == bfr_pkg::BFR_DONE && cmd_q.kind == bfr_pkg::BFR_CMD_BITMAP);
   COV_MS: cover property (@(posedge ref_clk_i) disable iff (rst_i) fvalid_q && ms_q);
   COV_PIXRECT: cover property (@(posedge ref_clk_i) disable iff (rst_i) fvalid_q && is_pr);
   COV_ERR: cover property (@(posedge ref_clk_i) disable iff (rst_i) fb_err_set);
   COV_ZOOM: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      fvalid_q && is_pr && (sub_x_q != 16'h0000));
endmodule // bfr_rasterizer
`default_nettype wire

// ===== tb/bfr_sink.sv
// bfr_sink.sv: downstream fragment pipeline model that accepts and records fragments.
// Assumes the rasterizer holds frag_valid until the ready level is seen at a clock edge.
`timescale 1ns/100ps
`default_nettype none
module bfr_sink (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire bfr_pkg::bfr_frag_s frag_i,
   input wire logic frag_valid_i,
   input wire logic slow_i,
   output logic frag_ready_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // slow mode accepts one cycle in four so the rasterizer must hold its output
   bfr_pkg::bfr_frag_s got_q[$];
   logic [1:0] tick_q;
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_q <= 2'h0;
         frag_ready_o <= 1'b0;
      end else begin
         tick_q <= tick_q + 2'h1;
         frag_ready_o <= !slow_i || (tick_q == 2'h2);
         if (frag_valid_i && frag_ready_o) begin
            got_q.push_back(frag_i);
         end
      end
   end
endmodule // bfr_sink
`default_nettype wire

// ===== tb/tb_bfr_rasterizer.sv
// tb_bfr_rasterizer.sv: self-checking bench with a queue model of the expected fragments.
// Assumes bfr_map.svh on the include path and the sink model beside it.
`include "bfr_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_bfr_rasterizer;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   bfr_pkg::bfr_cmd_s cmd_i = '0;
   logic cmd_valid_i = 1'b0;
   logic cmd_ready_o, bit_i = 1'b0, bit_valid_i = 1'b0, bit_ready_o, cmpl = 1'b1, slow = 1'b0;
   bfr_pkg::bfr_frag_s frag_o;
   logic frag_valid_o, frag_ready;
   int error_cnt = 0;
   int samples_checked = 0;
   int rx = 5, ry = 9;
   int zx = 1, zy = 1;
   logic [31:0] lf = 32'h3395C8DB;
   logic [31:0] rd;
   bfr_pkg::bfr_frag_s e;
   bfr_pkg::bfr_frag_s exp_q[$];
   logic bits_q[$];
   always #5 ref_clk_i = ~ref_clk_i;
   bfr_rasterizer #(.SAMPLES(4)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .bit_i(bit_i),
      .bit_valid_i(bit_valid_i), .bit_ready_o(bit_ready_o), .draw_target_complete_i(cmpl),
      .frag_o(frag_o), .frag_valid_o(frag_valid_o), .frag_ready_i(frag_ready));
   bfr_sink u_sink (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .frag_i(frag_o), .frag_valid_i(frag_valid_o),
      .slow_i(slow), .frag_ready_o(frag_ready));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [159:0] seen, input logic [159:0] expv);
      samples_checked++;
      if (seen !== expv) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      // data stand for one cycle only; take them at the edge that closes it
      @(posedge ref_clk_i);
      rd = reg_rdata_o;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // one command: model the fragments, drive command and bits, then compare everything
   task automatic draw(input bfr_pkg::bfr_cmd_e k, input int w, input int h, input int xo, input int yo,
                       input int xi, input int yi, input bit ms, input bit ok);
      int n;
      exp_q.delete();
      bits_q.delete();
      u_sink.got_q.delete();
      for (int r = 0; r < h; r++) begin
         for (int c = 0; c < w; c++) begin
            lf = lfsr(lf);
            bits_q.push_back(lf[0]);
            e = '0;
            e.x = 16'(ms ? rx + c : rx - xo + c);
            e.y = 16'(ms ? ry + r : ry - yo + r);
            e.z = 32'h1234_5678;
            e.color = 32'hCAFE_0042;
            e.fog = 16'h0BEE;
            e.texc = 32'h00AB_CDEF;
            e.cov = (ms || k == bfr_pkg::BFR_CMD_PIXRECT) ? 4'hF : 4'h0;
            if (lf[0] && k == bfr_pkg::BFR_CMD_BITMAP) exp_q.push_back(e);
            // a zoomed group covers |zx| by |zy| pixels, lowest row of the footprint first
            for (int sy = 0; k == bfr_pkg::BFR_CMD_PIXRECT && sy < (zy < 0 ? -zy : zy); sy++) begin
               for (int sx = 0; sx < (zx < 0 ? -zx : zx); sx++) begin
                  e.x = 16'(rx + zx * c + (zx < 0 ? zx : 0) + sx);
                  e.y = 16'(ry + zy * r + (zy < 0 ? zy : 0) + sy);
                  exp_q.push_back(e);
               end
            end
         end
      end
      @(posedge ref_clk_i);
      cmd_i <= '{k, 8'(w), 8'(h), 16'(xo), 16'(yo), 16'(xi), 16'(yi)};
      cmd_valid_i <= 1'b1;
      n = 0;
      do @(posedge ref_clk_i); while (cmd_ready_o !== 1'b1 && ++n < 50);
      cmd_valid_i <= 1'b0;
      while (ok && bits_q.size() > 0) begin
         bit_i <= bits_q.pop_front(); // raw stipple bits, bottom row first, leftmost first
         bit_valid_i <= 1'b1;
         n = 0;
         do @(posedge ref_clk_i); while (bit_ready_o !== 1'b1 && ++n < 60);
      end
      bit_valid_i <= 1'b0;
      n = 0;
      do rdr(`BFR_REG_STATUS); while (rd[`BFR_STAT_BUSY] !== 1'b0 && ++n < 60);
      // the last fragment may still wait for a slow sink after the walk ends
      n = 0;
      while (frag_valid_o !== 1'b0 && ++n < 20) @(posedge ref_clk_i);
      if (!ok) exp_q.delete();
      check(u_sink.got_q.size(), exp_q.size());
      foreach (exp_q[i]) begin
         if (i < u_sink.got_q.size()) begin
            e = u_sink.got_q[i];
            check(e, exp_q[i]); // position and shared data
         end
      end
      if (ok && k == bfr_pkg::BFR_CMD_BITMAP) begin
         rx = rx + xi;
         ry = ry + yi;
      end
      rdr(`BFR_REG_RPOS_X);
      check(rd, 32'(rx));
      rdr(`BFR_REG_RPOS_Y);
      check(rd, 32'(ry));
      rdr(`BFR_REG_RPOS_Z);
      check(rd, 32'h1234_5678);
      rdr(`BFR_REG_RPOS_W);
      check(rd, 32'h0000_0077);
      $display("test done: kind=%0d ms=%0d", k, ms);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #300000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rdr(`BFR_REG_CTRL);
      check(rd, `BFR_CTRL_RESET);
      rdr(`BFR_REG_ZOOM);
      check(rd, `BFR_ZOOM_RESET);
      rdr(8'h40);
      check(rd, 32'h0);
      wr(`BFR_REG_RPOS_X, 32'(rx));
      wr(`BFR_REG_RPOS_Y, 32'(ry));
      wr(`BFR_REG_RPOS_Z, 32'h1234_5678);
      wr(`BFR_REG_RPOS_W, 32'h0000_0077);
      wr(`BFR_REG_COLOR, 32'hCAFE_0042);
      wr(`BFR_REG_FOG, 32'h0000_0BEE);
      wr(`BFR_REG_TEXC, 32'h00AB_CDEF);
      wr(`BFR_REG_CTRL, 32'h0000_0002);
      draw(bfr_pkg::BFR_CMD_BITMAP, 3, 2, 1, 2, 4, -3, 1'b0, 1'b1);
      slow <= 1'b1;
      draw(bfr_pkg::BFR_CMD_BITMAP, 8, 3, 0, 1, -2, 6, 1'b0, 1'b1);
      cmpl <= 1'b0;
      draw(bfr_pkg::BFR_CMD_BITMAP, 2, 2, 0, 0, 7, 7, 1'b0, 1'b0);
      rdr(`BFR_REG_STATUS);
      check(rd[`BFR_STAT_FB_ERR], 1'b1);
      cmpl <= 1'b1;
      wr(`BFR_REG_STATUS, 32'h0000_0002);
      rdr(`BFR_REG_STATUS);
      check(rd[`BFR_STAT_FB_ERR], 1'b0);
      wr(`BFR_REG_CTRL, 32'h0000_0101);
      draw(bfr_pkg::BFR_CMD_BITMAP, 2, 2, 0, 0, 1, 1, 1'b1, 1'b0);
      rdr(`BFR_REG_STATUS);
      check(rd[`BFR_STAT_IGNORED], 1'b1);
      draw(bfr_pkg::BFR_CMD_PIXRECT, 2, 2, 0, 0, 0, 0, 1'b1, 1'b0);
      wr(`BFR_REG_CTRL, 32'h0000_0103);
      zx = 2;
      zy = -1;
      wr(`BFR_REG_ZOOM, {16'(zy), 16'(zx)});
      draw(bfr_pkg::BFR_CMD_BITMAP, 4, 3, 2, 2, 3, -1, 1'b1, 1'b1);
      slow <= 1'b0;
      draw(bfr_pkg::BFR_CMD_PIXRECT, 3, 2, 0, 0, 0, 0, 1'b1, 1'b1);
      wr(`BFR_REG_CTRL, 32'h0000_0203);
      draw(bfr_pkg::BFR_CMD_BITMAP, 2, 2, 1, 1, 1, 1, 1'b0, 1'b1);
      draw(bfr_pkg::BFR_CMD_NONE, 2, 2, 0, 0, 5, 5, 1'b0, 1'b0);
      conclude();
   end
endmodule // tb_bfr_rasterizer
`default_nettype wire
